// file: hs_fault_params.svh
// Purpose: Constants for the high-side switch fault-protection block.
// Assumes: 20 MHz system clock; classic Wishbone register access.
// Notes: Offsets are byte addresses of 32-bit registers.
`ifndef HS_FAULT_PARAMS_SVH
`define HS_FAULT_PARAMS_SVH
`define ADR_STATUS 8'h00
`define ADR_GCFG 8'h04
`define ADR_CH0 8'h08
`define ADR_CH1 8'h0c
`define ADR_CTRL 8'h10
`define GCFG_RST 32'h0000_0000
`define CH_RST 32'h0000_0000
`define WIN_DEFAULT 16'h0100
`define RETRY_TIME_US 1000
`define CLK_MHZ 20
`define RETRY_CYC ((`RETRY_TIME_US) * (`CLK_MHZ))
`endif

// file: hs_fault_pkg.sv
// Purpose: Types for the high-side switch fault-protection block.
// Assumes: Nothing beyond the constants header.
// Notes: Holds the channel fault record.
package hs_fault_pkg;
    typedef struct packed {
        logic overcurrent_flag;
        logic short_circuit_flag;
        logic overtemperature_flag;
        logic open_load_flag;
    } ch_faults_t;
    typedef enum logic [1:0] {CH_OFF, CH_ON, CH_LATCHED, CH_RETRY} ch_state_t;
endpackage

// file: hs_fault_protect.sv
// Purpose: Fault protection of a dual high-side switch with Wishbone registers.
// Assumes: Analog comparator results arrive as synchronous inputs.
// Notes: Channel logic is one generate loop over two channels.
//
// The register offsets and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`include "hs_fault_params.svh"
module hs_fault_protect (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic [1:0] i_on_request,
    input wire logic [1:0] i_switch_mode,
    input wire logic [1:0] i_load_profile_select,
    input wire logic [1:0] i_in_window,
    input wire logic [1:0] i_short_at_turn_on,
    input wire logic [1:0] i_overtemp,
    input wire logic [1:0] i_load_gnd_lost,
    input wire logic i_system_gnd_lost,
    input wire logic i_supply_ov,
    input wire logic i_supply_ov_clear,
    input wire logic i_supply_uv,
    input wire logic i_supply_below_6v,
    input wire logic i_supply_reset,
    output logic [1:0] o_channel_output,
    output logic [1:0] o_fast_off,
    output logic o_fault_status_out_n
);
    logic [31:0] general_config_reg_r;
    logic [15:0] win_r [2];
    logic [1:0] retry_en_r;
    logic [1:0] delatch_p;
    logic status_rd_p;
    logic [1:0] ch_rd_p;
    logic ov_latched_r;
    logic overvoltage_flag_r;
    logic undervoltage_flag_r;
    logic uv_fault_r;
    logic [1:0] uv_retry_p;
    logic uv_prev_r;
    logic [1:0] ch_fault_n;
    logic [1:0] ch_on;
    logic [1:0] ot_pending_r;
    hs_fault_pkg::ch_faults_t flags_r [2];
    logic overvoltage_protect_disable;
    logic wb_hit;
    assign overvoltage_protect_disable = general_config_reg_r[0];
    assign wb_hit = i_wb_cyc && i_wb_stb && !o_wb_ack;
    // Register writes.
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            general_config_reg_r <= `GCFG_RST;
            win_r[0] <= `WIN_DEFAULT;
            win_r[1] <= `WIN_DEFAULT;
            retry_en_r <= 2'h0;
        end else if (i_supply_reset) begin
            general_config_reg_r <= `GCFG_RST;
            retry_en_r <= 2'h0;
        end else if (wb_hit && i_wb_we && i_wb_sel[0]) begin
            if (i_wb_adr == `ADR_GCFG) begin
                general_config_reg_r <= {24'h0, i_wb_dat[7:0]};
            end else if (i_wb_adr == `ADR_CH0) begin
                win_r[0] <= i_wb_dat[15:0];
                retry_en_r[0] <= i_wb_dat[16];
            end else if (i_wb_adr == `ADR_CH1) begin
                win_r[1] <= i_wb_dat[15:0];
                retry_en_r[1] <= i_wb_dat[16];
            end
        end
    end
    assign delatch_p[0] = wb_hit && i_wb_we && i_wb_adr == `ADR_CTRL && i_wb_dat[0];
    assign delatch_p[1] = wb_hit && i_wb_we && i_wb_adr == `ADR_CTRL && i_wb_dat[1];
    assign status_rd_p = wb_hit && !i_wb_we && i_wb_adr == `ADR_STATUS;
    assign ch_rd_p[0] = wb_hit && !i_wb_we && i_wb_adr == `ADR_CH0;
    assign ch_rd_p[1] = wb_hit && !i_wb_we && i_wb_adr == `ADR_CH1;
    // Bus answer, one cycle after the request.
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0;
        end else begin
            o_wb_ack <= wb_hit;
            if (wb_hit && !i_wb_we) begin
                if (i_wb_adr == `ADR_STATUS) begin
                    o_wb_dat <= {26'h0, ch_on, uv_fault_r, ov_latched_r,
                        undervoltage_flag_r, overvoltage_flag_r};
                end else if (i_wb_adr == `ADR_GCFG) begin
                    o_wb_dat <= general_config_reg_r;
                end else if (i_wb_adr == `ADR_CH0) begin
                    o_wb_dat <= {11'h0, flags_r[0], retry_en_r[0], win_r[0]};
                end else if (i_wb_adr == `ADR_CH1) begin
                    o_wb_dat <= {11'h0, flags_r[1], retry_en_r[1], win_r[1]};
                end else begin
                    o_wb_dat <= 32'h0;
                end
            end
        end
    end
    // Overvoltage: latch off, flag, and read-clear once gone.
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            ov_latched_r <= 1'b0;
            overvoltage_flag_r <= 1'b0;
        end else if (i_supply_reset) begin
            ov_latched_r <= 1'b0;
            overvoltage_flag_r <= 1'b0;
        end else begin
            if (i_supply_ov && !overvoltage_protect_disable) begin
                ov_latched_r <= 1'b1;
            end else if (i_supply_ov_clear || overvoltage_protect_disable) begin
                ov_latched_r <= 1'b0;
            end
            if (i_supply_ov) begin
                overvoltage_flag_r <= 1'b1;
            end else if (status_rd_p && !ov_latched_r) begin
                overvoltage_flag_r <= 1'b0;
            end
        end
    end
    // Undervoltage: shared flag, fault hold, retry start on recovery.
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            undervoltage_flag_r <= 1'b0;
            uv_fault_r <= 1'b0;
            uv_prev_r <= 1'b0;
        end else if (i_supply_reset) begin
            undervoltage_flag_r <= 1'b0;
            uv_fault_r <= 1'b0;
            uv_prev_r <= 1'b0;
        end else begin
            uv_prev_r <= i_supply_uv;
            if (i_supply_uv) begin
                undervoltage_flag_r <= 1'b1;
                uv_fault_r <= 1'b1;
            end else begin
                if (uv_fault_r && (i_on_request == 2'b00 || delatch_p != 2'b00)) begin
                    uv_fault_r <= 1'b0;
                end
                if ((status_rd_p && !uv_fault_r) || ch_on != 2'b00) begin
                    undervoltage_flag_r <= 1'b0;
                end
            end
        end
    end
    assign uv_retry_p = {2{uv_prev_r && !i_supply_uv}} & retry_en_r;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen_ch
            hs_fault_pkg::ch_state_t state_r;
            logic [15:0] dur_r;
            logic [23:0] retry_cnt_r;
            logic on_prev_r;
            logic clean_r;
            logic trip;
            logic hs_on;
            logic global_off;
            assign hs_on = state_r == hs_fault_pkg::CH_ON;
            assign global_off = ov_latched_r || i_supply_uv || uv_fault_r || i_system_gnd_lost;
            assign trip = hs_on && i_in_window[g] && dur_r >= win_r[g];
            assign ch_on[g] = hs_on && !global_off;
            assign ch_fault_n[g] = !(state_r == hs_fault_pkg::CH_LATCHED
                || state_r == hs_fault_pkg::CH_RETRY);
            // Duration counter over profile window during on-times.
            always_ff @(posedge i_clk_sys or negedge i_rstn) begin
                if (!i_rstn) begin
                    dur_r <= 16'h0;
                    on_prev_r <= 1'b0;
                    clean_r <= 1'b1;
                end else begin
                    on_prev_r <= ch_on[g];
                    if (ch_on[g] && i_in_window[g]) begin
                        clean_r <= 1'b0;
                    end else if (ch_on[g] && !on_prev_r) begin
                        clean_r <= 1'b1;
                    end
                    if (delatch_p[g]) begin
                        dur_r <= 16'h0;
                    end else if (!i_load_profile_select[g] && uv_retry_p[g]) begin
                        dur_r <= 16'h0;
                    end else if (!i_load_profile_select[g] && state_r ==
                            hs_fault_pkg::CH_RETRY && retry_cnt_r == 24'h0) begin
                        dur_r <= 16'h0;
                    end else if (i_load_profile_select[g] && on_prev_r && !ch_on[g]
                            && clean_r && !i_switch_mode[g]) begin
                        dur_r <= 16'h0;
                    end else if (ch_on[g] && i_in_window[g] && dur_r != 16'hffff) begin
                        dur_r <= dur_r + 16'h1;
                    end
                end
            end
            // Channel state: on, latched or waiting to retry.
            always_ff @(posedge i_clk_sys or negedge i_rstn) begin
                if (!i_rstn) begin
                    state_r <= hs_fault_pkg::CH_OFF;
                    retry_cnt_r <= 24'h0;
                end else if (i_supply_reset) begin
                    state_r <= hs_fault_pkg::CH_OFF;
                    retry_cnt_r <= 24'h0;
                end else begin
                    case (state_r)
                        hs_fault_pkg::CH_OFF: begin
                            if (i_on_request[g] && !global_off) begin
                                state_r <= hs_fault_pkg::CH_ON;
                            end
                        end
                        hs_fault_pkg::CH_ON: begin
                            if (i_short_at_turn_on[g] || trip || i_overtemp[g]) begin
                                state_r <= retry_en_r[g] ? hs_fault_pkg::CH_RETRY
                                    : hs_fault_pkg::CH_LATCHED;
                                retry_cnt_r <= 24'(`RETRY_CYC);
                            end else if (!i_on_request[g]) begin
                                state_r <= hs_fault_pkg::CH_OFF;
                            end
                        end
                        hs_fault_pkg::CH_RETRY: begin
                            if (delatch_p[g] || uv_retry_p[g]) begin
                                state_r <= hs_fault_pkg::CH_OFF;
                            end else if (retry_cnt_r == 24'h0) begin
                                state_r <= hs_fault_pkg::CH_OFF;
                            end else begin
                                retry_cnt_r <= retry_cnt_r - 24'h1;
                            end
                        end
                        default: begin
                            if (delatch_p[g]) begin
                                state_r <= hs_fault_pkg::CH_OFF;
                            end
                        end
                    endcase
                end
            end
            // Sticky fault flags; hardware set wins over read clear.
            always_ff @(posedge i_clk_sys or negedge i_rstn) begin
                if (!i_rstn) begin
                    flags_r[g] <= '0;
                    ot_pending_r[g] <= 1'b0;
                end else if (i_supply_reset) begin
                    flags_r[g] <= '0;
                    ot_pending_r[g] <= 1'b0;
                end else begin
                    if (i_overtemp[g] && i_supply_below_6v) begin
                        ot_pending_r[g] <= 1'b1;
                    end else if (!i_supply_uv) begin
                        ot_pending_r[g] <= 1'b0;
                    end
                    if (hs_on && i_short_at_turn_on[g]) begin
                        flags_r[g].short_circuit_flag <= 1'b1;
                    end else if (ch_rd_p[g] && ch_fault_n[g]) begin
                        flags_r[g].short_circuit_flag <= 1'b0;
                    end
                    if (trip) begin
                        flags_r[g].overcurrent_flag <= 1'b1;
                    end else if (ch_rd_p[g] && ch_fault_n[g]) begin
                        flags_r[g].overcurrent_flag <= 1'b0;
                    end
                    if ((i_overtemp[g] && !i_supply_uv) || (ot_pending_r[g] && !i_supply_uv)) begin
                        flags_r[g].overtemperature_flag <= 1'b1;
                    end else if (ch_rd_p[g] && ch_fault_n[g] && !i_overtemp[g]) begin
                        flags_r[g].overtemperature_flag <= 1'b0;
                    end
                    if (i_load_gnd_lost[g]) begin
                        flags_r[g].open_load_flag <= 1'b1;
                    end else if (ch_rd_p[g]) begin
                        flags_r[g].open_load_flag <= 1'b0;
                    end
                end
            end
            // Output and fast-off indication.
            always_ff @(posedge i_clk_sys or negedge i_rstn) begin
                if (!i_rstn) begin
                    o_channel_output[g] <= 1'b0;
                    o_fast_off[g] <= 1'b0;
                end else begin
                    o_channel_output[g] <= ch_on[g] && !trip && !i_short_at_turn_on[g]
                        && !i_overtemp[g];
                    o_fast_off[g] <= o_channel_output[g] && (trip || i_short_at_turn_on[g]
                        || i_overtemp[g] || i_supply_uv);
                end
            end
        end
    endgenerate
    // Fault-status output, active low.
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_fault_status_out_n <= 1'b1;
        end else begin
            o_fault_status_out_n <= &ch_fault_n && !ov_latched_r && !uv_fault_r
                && !i_supply_uv;
        end
    end
endmodule // hs_fault_protect

// file: hs_fault_protect_sva.sv
// Purpose: Concurrent checks on the ports of the fault-protection block.
// Assumes: One clock domain; reset is asynchronous and active low.
// Notes: Overvoltage disable is mirrored from Wishbone writes.
`timescale 1ns/1ps
`include "hs_fault_params.svh"
module hs_fault_protect_sva (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic o_wb_ack,
    input wire logic [1:0] i_short_at_turn_on,
    input wire logic i_system_gnd_lost,
    input wire logic i_supply_ov,
    input wire logic i_supply_ov_clear,
    input wire logic i_supply_uv,
    input wire logic [1:0] o_channel_output,
    input wire logic [1:0] o_fast_off,
    input wire logic o_fault_status_out_n
);
    logic overvoltage_protect_disable_r;
    logic ov_hold_r;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    // Mirrors the overvoltage disable bit as software writes it.
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            overvoltage_protect_disable_r <= 1'b0;
        end else if (i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack && i_wb_adr == `ADR_GCFG
                     && i_wb_sel[0]) begin
            overvoltage_protect_disable_r <= i_wb_dat[0];
        end
    end
    // Holds while an enabled overvoltage shutdown has not yet recovered.
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            ov_hold_r <= 1'b0;
        end else if (i_supply_ov && !overvoltage_protect_disable_r) begin
            ov_hold_r <= 1'b1;
        end else if (i_supply_ov_clear) begin
            ov_hold_r <= 1'b0;
        end
    end
    ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held longer than one cycle");
    ack_time_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("ack not given one cycle after request");
    uv_off_a: assert property (i_supply_uv |-> ##[1:2] (o_channel_output == 2'b00))
        else $error("channels on during undervoltage");
    uv_fault_a: assert property (i_supply_uv |-> ##[1:2] !o_fault_status_out_n)
        else $error("fault output high during undervoltage");
    gnd_off_a: assert property (i_system_gnd_lost |-> ##[1:2] (o_channel_output == 2'b00))
        else $error("channels on after system ground loss");
    sc_off_a: assert property (i_short_at_turn_on[1] && o_channel_output[1]
        |-> ##[1:2] (!o_channel_output[1] && !o_fault_status_out_n))
        else $error("short did not switch channel off");
    ov_off_a: assert property (ov_hold_r && $past(ov_hold_r) |-> o_channel_output == 2'b00)
        else $error("channel on during overvoltage shutdown");
    fast_off_a: assert property ($rose(i_supply_uv) && o_channel_output[0]
        |-> ##[1:2] o_fast_off[0])
        else $error("fault turn-off not fast");
endmodule // hs_fault_protect_sva
bind hs_fault_protect hs_fault_protect_sva hs_fault_protect_sva_i (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr),
    .i_wb_sel(i_wb_sel),
    .i_wb_dat(i_wb_dat),
    .o_wb_ack(o_wb_ack),
    .i_short_at_turn_on(i_short_at_turn_on),
    .i_system_gnd_lost(i_system_gnd_lost),
    .i_supply_ov(i_supply_ov),
    .i_supply_ov_clear(i_supply_ov_clear),
    .i_supply_uv(i_supply_uv),
    .o_channel_output(o_channel_output),
    .o_fast_off(o_fast_off),
    .o_fault_status_out_n(o_fault_status_out_n)
);

// file: hs_switch_fault_protection_tb.sv
// Purpose: Self-checking bench for the fault-protection block.
// Assumes: Ack comes one cycle after a request is taken.
// Notes: Outputs are sampled right after a clock edge.
`timescale 1ns/1ps
`include "hs_fault_params.svh"
module hs_switch_fault_protection_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic [1:0] on_req = 2'b00;
    logic [1:0] sw_mode = 2'b00;
    logic [1:0] in_win = 2'b00;
    logic [1:0] short_on = 2'b00;
    logic gnd_lost = 1'b0;
    logic ov = 1'b0;
    logic ov_clr = 1'b0;
    logic uv = 1'b0;
    logic [1:0] lps = 2'b00;
    logic [1:0] ot = 2'b00;
    logic [1:0] lgnd = 2'b00;
    logic b6v = 1'b0;
    logic sreset = 1'b0;
    logic [1:0] ch_out;
    logic [1:0] fast_off;
    logic fault_n;
    logic [31:0] rd;
    int n_fail = 0;
    int n_compared = 0;
    hs_fault_protect hs_fault_protect_i (.i_clk_sys(clk), .i_rstn(rstn), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_on_request(on_req), .i_switch_mode(sw_mode),
        .i_load_profile_select(lps), .i_in_window(in_win), .i_short_at_turn_on(short_on),
        .i_overtemp(ot), .i_load_gnd_lost(lgnd), .i_system_gnd_lost(gnd_lost),
        .i_supply_ov(ov), .i_supply_ov_clear(ov_clr), .i_supply_uv(uv),
        .i_supply_below_6v(b6v), .i_supply_reset(sreset), .o_channel_output(ch_out),
        .o_fast_off(fast_off), .o_fault_status_out_n(fault_n));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Drives one on-period of channel 0 and then an off-period.
    task automatic pulse0(input logic w, input int n_on, input int n_off);
        in_win <= {1'b0, w};
        on_req <= 2'b01;
        cycles(n_on);
        on_req <= 2'b00;
        cycles(n_off);
    endtask
    // One classic Wishbone cycle, entered just after a clock edge.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        @(posedge clk);
        while (ack !== 1'b1 && t < 20) begin
            @(posedge clk);
            t++;
        end
        if (ack !== 1'b1) n_fail++;
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
        @(posedge clk);
    endtask
    task automatic tally_and_finish;
        $display("Compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge clk);
        n_fail++;
        tally_and_finish;
    end
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        wb(1'b0, `ADR_GCFG, 32'h0);
        check("gcfg reset", rd, `GCFG_RST);
        wb(1'b0, `ADR_CH0, 32'h0);
        check("ch0 reset", rd, {16'h0000, `WIN_DEFAULT});
        wb(1'b0, 8'h20, 32'h0);
        check("unmapped read", rd, 32'h0);
        on_req <= 2'b11;
        wb(1'b1, `ADR_GCFG, 32'h1);
        ov <= 1'b1;
        cycles(4);
        check("ov warn outputs", 32'(ch_out), 32'h3);
        check("ov warn fault", 32'(fault_n), 32'h1);
        wb(1'b0, `ADR_STATUS, 32'h0);
        check("ov warn flag", 32'(rd[0]), 32'h1);
        ov <= 1'b0;
        ov_clr <= 1'b1;
        cycles(2);
        wb(1'b0, `ADR_STATUS, 32'h0);
        wb(1'b1, `ADR_GCFG, 32'h0);
        ov_clr <= 1'b0;
        ov <= 1'b1;
        cycles(3);
        check("ov outputs", 32'(ch_out), 32'h0);
        check("ov fault", 32'(fault_n), 32'h0);
        wb(1'b0, `ADR_STATUS, 32'h0);
        wb(1'b0, `ADR_STATUS, 32'h0);
        check("ov flag kept", 32'(rd[0]), 32'h1);
        ov <= 1'b0;
        cycles(4);
        check("ov hysteresis", 32'(ch_out), 32'h0);
        ov_clr <= 1'b1;
        cycles(2);
        wb(1'b0, `ADR_STATUS, 32'h0);
        wb(1'b0, `ADR_STATUS, 32'h0);
        check("ov flag read clear", 32'(rd[0]), 32'h0);
        ov_clr <= 1'b0;
        wb(1'b1, `ADR_CTRL, 32'h3);
        cycles(4);
        uv <= 1'b1;
        cycles(2);
        check("uv fast off", 32'(fast_off), 32'h3);
        cycles(1);
        check("uv outputs", 32'(ch_out), 32'h0);
        check("uv fault", 32'(fault_n), 32'h0);
        wb(1'b0, `ADR_STATUS, 32'h0);
        check("uv flag", 32'(rd[1]), 32'h1);
        on_req <= 2'b00;
        uv <= 1'b0;
        cycles(4);
        check("uv gone fault", 32'(fault_n), 32'h1);
        wb(1'b1, `ADR_CTRL, 32'h3);
        on_req <= 2'b11;
        cycles(4);
        lgnd <= 2'b01;
        cycles(3);
        check("load gnd keeps", 32'(ch_out), 32'h3);
        lgnd <= 2'b00;
        wb(1'b0, `ADR_CH0, 32'h0);
        check("open load flag", 32'(rd[17]), 32'h1);
        gnd_lost <= 1'b1;
        cycles(3);
        check("gnd loss outputs", 32'(ch_out), 32'h0);
        gnd_lost <= 1'b0;
        on_req <= 2'b10;
        wb(1'b1, `ADR_CTRL, 32'h3);
        cycles(4);
        short_on <= 2'b10;
        cycles(3);
        check("short output", 32'(ch_out[1]), 32'h0);
        check("short fault", 32'(fault_n), 32'h0);
        wb(1'b0, `ADR_CH1, 32'h0);
        check("short flag", 32'(rd[19]), 32'h1);
        short_on <= 2'b00;
        on_req <= 2'b00;
        wb(1'b1, `ADR_CTRL, 32'h2);
        wb(1'b1, `ADR_CH0, 32'h4);
        sw_mode <= 2'b01;
        in_win <= 2'b01;
        on_req <= 2'b01;
        cycles(2);
        on_req <= 2'b00;
        cycles(2);
        check("pwm first pulse", 32'(fault_n), 32'h1);
        repeat (6) begin
            on_req <= 2'b01;
            cycles(2);
            on_req <= 2'b00;
            cycles(2);
        end
        check("pwm trip fault", 32'(fault_n), 32'h0);
        wb(1'b0, `ADR_CH0, 32'h0);
        check("pwm trip flag", 32'(rd[20]), 32'h1);
        in_win <= 2'b00;
        sw_mode <= 2'b00;
        wb(1'b1, `ADR_CTRL, 32'h1);
        wb(1'b0, `ADR_CH0, 32'h0);
        in_win <= 2'b01;
        on_req <= 2'b01;
        cycles(4);
        check("delatch clears count", 32'(fault_n), 32'h1);
        in_win <= 2'b00;
        on_req <= 2'b00;
        lps <= 2'b01;
        cycles(2);
        pulse0(1'b0, 3, 2);
        pulse0(1'b1, 5, 0);
        check("motor clean clears", 32'(fault_n), 32'h1);
        sw_mode <= 2'b01;
        in_win <= 2'b00;
        cycles(2);
        pulse0(1'b0, 3, 2);
        pulse0(1'b1, 5, 0);
        check("pwm keeps count", 32'(fault_n), 32'h0);
        in_win <= 2'b00;
        sreset <= 1'b1;
        cycles(2);
        sreset <= 1'b0;
        wb(1'b0, `ADR_CH0, 32'h0);
        check("supply reset flags", 32'(rd[20]), 32'h0);
        check("supply reset fault", 32'(fault_n), 32'h1);
        uv <= 1'b1;
        b6v <= 1'b1;
        ot <= 2'b01;
        cycles(2);
        ot <= 2'b00;
        b6v <= 1'b0;
        wb(1'b0, `ADR_CH0, 32'h0);
        check("ot held back", 32'(rd[18]), 32'h0);
        uv <= 1'b0;
        cycles(2);
        wb(1'b0, `ADR_CH0, 32'h0);
        check("ot reported", 32'(rd[18]), 32'h1);
        tally_and_finish;
    end
endmodule // hs_switch_fault_protection_tb
